// ==== src/fsp_pkg.sv ====
// Constants shared by the flash self-programming sequencer and its page buffer.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register port.
package fsp_pkg;
  // Register byte offsets
  localparam logic [3:0]  REG_CTRL_OFS   = 4'h0;
  localparam logic [3:0]  REG_PTR_OFS    = 4'h4;
  localparam logic [3:0]  REG_DATA_OFS   = 4'h8;
  localparam logic [3:0]  REG_STAT_OFS   = 4'hC;
  // Control register command codes and fields
  localparam logic [7:0]  CMD_LOAD       = 8'h01;
  localparam logic [7:0]  CMD_ERASE      = 8'h03;
  localparam logic [7:0]  CMD_WRITE      = 8'h05;
  localparam logic [7:0]  CTRL_WR_MASK   = 8'h1F;
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_CLR_BIT   = 4;
  // Status register fields
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_ARM_BIT   = 1;
  localparam int          STAT_REF_BIT   = 2;
  localparam int          STAT_LOAD_BIT  = 3;
  localparam int          STAT_FUSE_BIT  = 4;
  // Fuse reads 0 when programmed
  localparam logic        FUSE_PROGRAMMED = 1'b0;
  // Command window after a control write, in clock cycles
  localparam logic [2:0]  WINDOW_CYCLES  = 3'h4;
  // Erased word value held by the page buffer
  localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
  // Flash operation time, microseconds, and clock rate
  localparam int          PROG_MIN_US    = 3700;
  localparam int          PROG_MAX_US    = 4500;
  localparam int          CLK_MHZ        = 50;
  localparam int          PROG_MIN_CYC   = PROG_MIN_US * CLK_MHZ;
  localparam int          PROG_MAX_CYC   = PROG_MAX_US * CLK_MHZ;
  localparam int          TMR_W          = 24;
endpackage

// ==== src/fsp_buf_if.sv ====
// Connection between the sequencer and its temporary page buffer.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface fsp_buf_if #(
  parameter int WORD_BITS = 5
);
  logic                 wr_en;
  logic [WORD_BITS-1:0] wr_idx;
  logic [15:0]          wr_data;
  logic                 clr;
  logic [WORD_BITS-1:0] rd_idx;
  logic [15:0]          rd_data;
  logic                 any_loaded;
  modport seq   (output wr_en, wr_idx, wr_data, clr, rd_idx, input rd_data, any_loaded);
  modport store (input wr_en, wr_idx, wr_data, clr, rd_idx, output rd_data, any_loaded);
endinterface

// ==== src/fsp_page_buf.sv ====
// Temporary page buffer: one flip-flop word per page location.
// Assumes the sequencer issues loads and clears through fsp_buf_if.
`timescale 1ns/1ps
module fsp_page_buf
  import fsp_pkg::*;
#(
  parameter int WORD_BITS = 5
)
(
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_resetn,
  // Sequencer side
  fsp_buf_if.store   bus
);
  localparam int DEPTH = 1 << WORD_BITS;

  logic [15:0]      mem_q [DEPTH];
  logic [DEPTH-1:0] used_q;

  // Storage is cleared by reset, so no stale words survive it
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= ERASED_WORD;
    end
    else if (bus.clr)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= ERASED_WORD;
    end
    else if (bus.wr_en && !used_q[bus.wr_idx])
    begin
      mem_q[bus.wr_idx] <= bus.wr_data;
    end
  end

  // A second load to a location keeps the first word
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      used_q <= '0;
    else if (bus.clr)
      used_q <= '0;
    else if (bus.wr_en)
      used_q[bus.wr_idx] <= 1'b1;
  end

  assign bus.rd_data    = mem_q[bus.rd_idx];
  assign bus.any_loaded = |used_q;
endmodule

// ==== src/fsp_seq.sv ====
// Flash self-programming sequencer: command register, store-program window,
// page erase, buffer load and page write with core halt.
// Assumes the core pulses i_store_program_instr for one cycle per instruction
// and the flash array outside takes erase and word-program strobes.
`timescale 1ns/1ps
module fsp_seq
  import fsp_pkg::*;
#(
  parameter int WORD_BITS   = 5,
  parameter int PAGE_BITS   = 7,
  parameter int PROG_CYCLES = PROG_MIN_CYC
)
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  // Avalon-MM register slave
  input  wire logic [3:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  output logic [31:0]               o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // Core and system
  input  wire logic                 i_store_program_instr,
  input  wire logic                 i_selfprog_enable_fuse,
  input  wire logic                 i_eeprom_write,
  output logic                      o_core_halt,
  // Flash array
  output logic                      o_flash_erase,
  output logic                      o_flash_word_we,
  output logic [PAGE_BITS-1:0]      o_flash_page,
  output logic [WORD_BITS-1:0]      o_flash_word_idx,
  output logic [15:0]               o_flash_word_data
);
  localparam int PAGE_LSB = WORD_BITS + 1;

  initial
  begin
    if (WORD_BITS < 1 || PAGE_BITS < 1 || WORD_BITS + PAGE_BITS + 1 > 16)
      $error("fsp_seq: pointer fields do not fit 16 bits");
    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << TMR_W) || PROG_CYCLES > PROG_MAX_CYC)
      $error("fsp_seq: PROG_CYCLES out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STREAM,
    ST_TIMED
  } fsp_state_type;

  function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] ptr);
    page_of = ptr[PAGE_LSB +: PAGE_BITS];
  endfunction

  function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] ptr);
    word_of = ptr[1 +: WORD_BITS];
  endfunction

  fsp_buf_if #(.WORD_BITS(WORD_BITS)) buf_bus ();

  fsp_page_buf #(
    .WORD_BITS (WORD_BITS)
  ) u_buf (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .bus      (buf_bus)
  );

  fsp_state_type        state_q;
  logic [7:0]           ctrl_q;
  logic [15:0]          ptr_q;
  logic [15:0]          data_q;
  logic [2:0]           win_q;
  logic                 refused_q;
  logic                 is_write_q;
  logic [TMR_W-1:0]     tmr_q;
  logic [WORD_BITS-1:0] idx_q;
  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic                 halt_q;
  logic                 erase_q;
  logic                 we_q;
  logic [PAGE_BITS-1:0] page_q;
  logic [WORD_BITS-1:0] widx_q;
  logic [15:0]          wdata_q;

  // Bus request decode
  logic       bus_req;
  logic       wr_take;
  logic       ctrl_wr;
  logic       clr_req;
  logic       spm_hit;
  logic       spm_ok;
  logic [7:0] cmd;

  assign bus_req = i_avs_read || i_avs_write;
  assign wr_take = i_avs_write && !wait_q;
  assign ctrl_wr = wr_take && (i_avs_address == REG_CTRL_OFS) && (state_q == ST_IDLE);
  assign clr_req = ctrl_wr && i_avs_writedata[CTRL_CLR_BIT];
  assign cmd     = ctrl_q & ~(8'h01 << CTRL_CLR_BIT);
  assign spm_hit = i_store_program_instr && (win_q != 3'h0) && (state_q == ST_IDLE);
  assign spm_ok  = spm_hit && (i_selfprog_enable_fuse == FUSE_PROGRAMMED);

  // One wait cycle per access; the write lands at the edge that acks it
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      wait_q <= 1'b1;
    else if (bus_req && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rdata_q <= '0;
    else if (i_avs_read && wait_q)
    begin
      case (i_avs_address)
        REG_CTRL_OFS: rdata_q <= {24'h0, ctrl_q};
        REG_PTR_OFS:  rdata_q <= {16'h0, ptr_q};
        REG_DATA_OFS: rdata_q <= {16'h0, data_q};
        REG_STAT_OFS:
        begin
          rdata_q                <= '0;
          rdata_q[STAT_BUSY_BIT] <= halt_q;
          rdata_q[STAT_ARM_BIT]  <= (win_q != 3'h0);
          rdata_q[STAT_REF_BIT]  <= refused_q;
          rdata_q[STAT_LOAD_BIT] <= buf_bus.any_loaded;
          rdata_q[STAT_FUSE_BIT] <= i_selfprog_enable_fuse;
        end
        default:      rdata_q <= '0;
      endcase
    end
  end

  // Address pointer and load data pair
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ptr_q  <= '0;
      data_q <= '0;
    end
    else if (wr_take && i_avs_address == REG_PTR_OFS)
      ptr_q <= i_avs_writedata[15:0];
    else if (wr_take && i_avs_address == REG_DATA_OFS)
      data_q <= i_avs_writedata[15:0];
  end

  // Command register and its four-cycle window
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_q <= '0;
      win_q  <= '0;
    end
    else if (ctrl_wr)
    begin
      // The clear bit acts once and is not held
      ctrl_q <= i_avs_writedata[7:0] & CTRL_WR_MASK & ~(8'h01 << CTRL_CLR_BIT);
      win_q  <= i_avs_writedata[CTRL_EN_BIT] ? WINDOW_CYCLES : 3'h0;
    end
    else if (spm_hit)
    begin
      ctrl_q <= '0;
      win_q  <= '0;
    end
    else if (win_q == 3'h1)
    begin
      ctrl_q <= '0;
      win_q  <= '0;
    end
    else if (win_q != 3'h0)
      win_q <= win_q - 3'h1;
  end

  // Refused instruction flag; a new control write clears it, a refusal wins
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      refused_q <= 1'b0;
    else if (spm_hit && !spm_ok)
      refused_q <= 1'b1;
    else if (ctrl_wr)
      refused_q <= 1'b0;
  end

  // Buffer loads and clears
  always_comb
  begin
    buf_bus.wr_en   = spm_ok && (cmd == CMD_LOAD);
    buf_bus.wr_idx  = word_of(ptr_q);
    buf_bus.wr_data = data_q;
    buf_bus.clr     = clr_req || i_eeprom_write
                      || (state_q == ST_TIMED && is_write_q && tmr_q == '0);
    buf_bus.rd_idx  = idx_q;
  end

  // Erase and write sequence
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q    <= ST_IDLE;
      is_write_q <= 1'b0;
      tmr_q      <= '0;
      idx_q      <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          idx_q <= '0;
          if (spm_ok && cmd == CMD_ERASE)
          begin
            is_write_q <= 1'b0;
            tmr_q      <= TMR_W'(PROG_CYCLES - 1);
            state_q    <= ST_TIMED;
          end
          else if (spm_ok && cmd == CMD_WRITE)
          begin
            is_write_q <= 1'b1;
            state_q    <= ST_STREAM;
          end
        end
        ST_STREAM:
        begin
          // Whole page goes out, one word per cycle
          idx_q <= idx_q + 1'b1;
          if (&idx_q)
          begin
            tmr_q   <= TMR_W'(PROG_CYCLES - 1);
            state_q <= ST_TIMED;
          end
        end
        ST_TIMED:
        begin
          if (tmr_q == '0)
            state_q <= ST_IDLE;
          else
            tmr_q <= tmr_q - 1'b1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Core halt spans the start edge through the end of the timed phase
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      halt_q <= 1'b0;
    else if (spm_ok && (cmd == CMD_ERASE || cmd == CMD_WRITE))
      halt_q <= 1'b1;
    else if (state_q == ST_TIMED && tmr_q == '0)
      halt_q <= 1'b0;
  end

  // Flash strobes; the page comes from the page field only
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      erase_q <= 1'b0;
      we_q    <= 1'b0;
      page_q  <= '0;
      widx_q  <= '0;
      wdata_q <= '0;
    end
    else
    begin
      erase_q <= spm_ok && (cmd == CMD_ERASE);
      we_q    <= (state_q == ST_STREAM);
      widx_q  <= idx_q;
      wdata_q <= buf_bus.rd_data;
      if (spm_ok && (cmd == CMD_ERASE || cmd == CMD_WRITE))
        page_q <= page_of(ptr_q);
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_core_halt       = halt_q;
  assign o_flash_erase     = erase_q;
  assign o_flash_word_we   = we_q;
  assign o_flash_page      = page_q;
  assign o_flash_word_idx  = widx_q;
  assign o_flash_word_data = wdata_q;
endmodule

// ==== sim/fsp_seq_properties.sv ====
// Port timing checks for fsp_seq.
// Assumes it is bound to fsp_seq and sees only its ports.
`timescale 1ns/1ps
module fsp_seq_chk #(
  parameter int WORD_BITS = 5,
  parameter int PAGE_BITS = 7
)
(
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_resetn,
  // Watched ports
  input wire logic                 i_store_program_instr,
  input wire logic                 i_selfprog_enable_fuse,
  input wire logic                 o_avs_waitrequest,
  input wire logic                 o_core_halt,
  input wire logic                 o_flash_erase,
  input wire logic                 o_flash_word_we,
  input wire logic [PAGE_BITS-1:0] o_flash_page,
  input wire logic [WORD_BITS-1:0] o_flash_word_idx
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_busy;
    o_core_halt [*8];
  endsequence
  sequence s_burst;
    (o_flash_word_idx == '0) ##0 o_flash_word_we [*8];
  endsequence
  AST_WAIT_ONE:
    assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("ack too long");
  AST_FUSE_OFF:
    assert property (i_store_program_instr && i_selfprog_enable_fuse
      |=> !o_flash_erase && !$rose(o_core_halt)) else $error("fuse ignored");
  AST_HALT_CAUSE:
    assert property ($rose(o_core_halt) |-> $past(i_store_program_instr))
      else $error("halt without instr");
  AST_ERASE_HALT:
    assert property (o_flash_erase |-> o_core_halt ##1 (o_core_halt && !o_flash_erase))
      else $error("erase pulse");
  AST_HALT_TIME:
    assert property ($rose(o_core_halt) |-> s_busy ##[1:1000] !o_core_halt)
      else $error("halt length");
  AST_STREAM:
    assert property ($rose(o_flash_word_we) |-> s_burst) else $error("stream start");
  AST_IDX_STEP:
    assert property (o_flash_word_we && $past(o_flash_word_we)
      |-> o_flash_word_idx == $past(o_flash_word_idx) + 1'b1) else $error("index step");
  AST_WE_HALT:
    assert property (o_flash_word_we |-> o_core_halt && !o_flash_erase)
      else $error("strobe outside write");
  AST_PAGE_HOLD:
    assert property (o_core_halt && $past(o_core_halt) |-> $stable(o_flash_page))
      else $error("page moved");
endmodule
bind fsp_seq fsp_seq_chk #(.WORD_BITS(WORD_BITS), .PAGE_BITS(PAGE_BITS)) u_chk (
  .i_clk, .i_resetn, .i_store_program_instr, .i_selfprog_enable_fuse, .o_avs_waitrequest,
  .o_core_halt, .o_flash_erase, .o_flash_word_we, .o_flash_page, .o_flash_word_idx);

// ==== sim/fsp_core_model.sv ====
// Core model: one store-program pulse a chosen delay after a request.
// Assumes the bench requests it at the edge where the command lands.
`timescale 1ns/1ps
module fsp_core_model
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Bench request
  input  wire logic       i_go,
  input  wire logic [2:0] i_dly,
  // Instruction strobe
  output logic            o_spm
);
  logic [3:0] cnt_q;
  // Delays 0 to 2 hit the window; larger delays model a late instruction
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_q <= 4'h0;
      o_spm <= 1'b0;
    end
    else
    begin
      o_spm <= i_go ? (i_dly == 3'h0) : (cnt_q == 4'h1);
      cnt_q <= i_go ? {1'b0, i_dly} : ((cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1);
    end
  end
endmodule

// ==== sim/tb_fsp_seq.sv ====
// Bench for fsp_seq: Avalon tasks, core model and flash stream capture.
// Assumes PROG_CYCLES is shortened to 20 cycles.
`timescale 1ns/1ps
module tb_fsp_seq
  import fsp_pkg::*;
;
  logic        i_clk, i_resetn, i_avs_read, i_avs_write, go;
  logic        o_avs_waitrequest, i_store_program_instr, i_selfprog_enable_fuse;
  logic        i_eeprom_write, o_core_halt, o_flash_erase, o_flash_word_we;
  logic [3:0]  i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd;
  logic [6:0]  o_flash_page, pg, pgs;
  logic [4:0]  o_flash_word_idx, ix;
  logic [15:0] o_flash_word_data, dv, cap [32], ex [32];
  logic [2:0]  dly;
  int          error_cnt, check_count, n_we, n_er, n0, n_h;
  fsp_seq #(.PROG_CYCLES(20)) dut_u (
    .i_clk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .o_avs_readdata, .o_avs_waitrequest, .i_store_program_instr, .i_selfprog_enable_fuse,
    .i_eeprom_write, .o_core_halt, .o_flash_erase, .o_flash_word_we, .o_flash_page,
    .o_flash_word_idx, .o_flash_word_data);
  fsp_core_model core_u (.i_clk, .i_resetn, .i_go(go), .i_dly(dly),
    .o_spm(i_store_program_instr));
  initial
  begin
    i_clk = 1'b0;
    forever
      #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    if (o_flash_word_we === 1'b1)
    begin
      cap[o_flash_word_idx] <= o_flash_word_data;
      n_we <= n_we + 1;
    end
    if (o_flash_erase === 1'b1)
      n_er <= n_er + 1;
    if (o_core_halt === 1'b1)
      n_h <= n_h + 1;
    if (o_flash_erase === 1'b1 || o_flash_word_we === 1'b1)
      pgs <= o_flash_page;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is sampled low; one idle edge after it
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic g);
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0)
      @(posedge i_clk);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    go <= g;
    @(posedge i_clk);
    go <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 1'b0);
    chk(rd & m, e);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] p, input logic [15:0] d,
                     input logic [2:0] dl);
    bus(1'b1, REG_PTR_OFS, {16'h0, p}, 1'b0);
    bus(1'b1, REG_DATA_OFS, {16'h0, d}, 1'b0);
    dly <= dl;
    bus(1'b1, REG_CTRL_OFS, {24'h0, c}, 1'b1);
    repeat (12) @(posedge i_clk);
    while (o_core_halt !== 1'b0)
      @(posedge i_clk);
  endtask
  task automatic perase(input logic [6:0] p);
    int h0;
    n0 = n_er;
    h0 = n_h;
    cmd(CMD_ERASE, {3'($urandom), p, 6'($urandom)}, 16'($urandom), 3'h1);
    chk(n_er - n0, 32'h1);
    chk(n_h - h0, 32'h14);
    chk(pgs, p);
  endtask
  task automatic pwrite(input logic [6:0] p);
    int h0;
    n0 = n_we;
    h0 = n_h;
    cmd(CMD_WRITE, {3'h0, p, 6'h0}, 16'($urandom), 3'h0);
    chk(n_we - n0, 32'h20);
    chk(n_h - h0, 32'h34);
    chk(pgs, p);
    for (int i = 0; i < 32; i++)
    begin
      chk(cap[i], ex[i]);
      ex[i] = ERASED_WORD;
    end
    rdc(REG_STAT_OFS, 32'h8, 32'h0);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    {i_resetn, i_avs_read, i_avs_write, go, i_selfprog_enable_fuse, i_eeprom_write} = 6'h0;
    i_avs_address = 4'h0;
    i_avs_writedata = 32'h0;
    dly = 3'h0;
    void'($urandom(32'h96CF5D0A));
    for (int i = 0; i < 32; i++)
      ex[i] = ERASED_WORD;
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    chk(o_avs_waitrequest, 32'h1);
    rdc(REG_STAT_OFS, 32'h1F, 32'h0);
    rdc(4'h2, 32'hFFFFFFFF, 32'h0);
    // Round 0 loads before the erase, round 1 after it
    for (int r = 0; r < 2; r++)
    begin
      pg = 7'($urandom);
      if (r == 1)
        perase(pg);
      ix = 5'($urandom);
      for (int k = 0; k < 6; k++)
      begin
        dv = 16'($urandom);
        ex[ix] = dv;
        cmd(CMD_LOAD, {3'h0, 7'($urandom), ix, 1'b0}, dv, 3'($urandom % 2));
        ix = ix + 5'h7;
      end
      rdc(REG_STAT_OFS, 32'h8, 32'h8);
      if (r == 0)
        perase(pg);
      pwrite(pg);
    end
    cmd(CMD_LOAD, 16'h0002, 16'h1234, 3'h0);
    bus(1'b1, REG_CTRL_OFS, 32'h10, 1'b0);
    rdc(REG_STAT_OFS, 32'h8, 32'h0);
    cmd(CMD_LOAD, 16'h0004, 16'h5678, 3'h1);
    i_eeprom_write <= 1'b1;
    @(posedge i_clk);
    i_eeprom_write <= 1'b0;
    rdc(REG_STAT_OFS, 32'h8, 32'h0);
    pwrite(7'h05);
    i_selfprog_enable_fuse <= 1'b1;
    n0 = n_er;
    cmd(CMD_ERASE, 16'h0040, 16'h0, 3'h0);
    chk(n_er - n0, 32'h0);
    rdc(REG_STAT_OFS, 32'h14, 32'h14);
    i_selfprog_enable_fuse <= 1'b0;
    cmd(CMD_LOAD, 16'h0006, 16'hABCD, 3'h7);
    rdc(REG_CTRL_OFS, 32'hFF, 32'h0);
    rdc(REG_STAT_OFS, 32'h8, 32'h0);
    cmd(CMD_LOAD, 16'h0008, 16'h0F0F, 3'h0);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rdc(REG_STAT_OFS, 32'h8, 32'h0);
    final_report();
  end
  initial
  begin
    #400000;
    error_cnt++;
    final_report();
  end
endmodule
